/* File: wdt_params.svh */
// Register map, field positions, reset values and timing counts of the watchdog block
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define WDT_ADDR_ACTIVATE    8'h30
`define WDT_ADDR_MODE        8'hf5
`define WDT_ADDR_COUNT       8'hf6
`define WDT_ADDR_CTRL        8'hf7

// ****************************************************************
// Field positions
// ****************************************************************
`define WDT_ACT_BIT          0
`define WDT_MODE_LED_HI      7
`define WDT_MODE_LED_LO      6
`define WDT_MODE_FAST_BIT    4
`define WDT_MODE_MINUTE_BIT  3
`define WDT_MODE_RSTEDGE_BIT 2
`define WDT_MODE_KEYBOARD_RESET_PIN_BIT   1
`define WDT_CTRL_MOUSE_BIT   7
`define WDT_CTRL_KBD_BIT     6
`define WDT_CTRL_TRIG_BIT    5
`define WDT_CTRL_STATUS_BIT  4
`define WDT_CTRL_SEL_HI      3
`define WDT_CTRL_SEL_LO      0
`define WDT_SEL_SMI          4'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define WDT_RST_ACTIVATE     8'h00
`define WDT_RST_MODE         8'h00
`define WDT_RST_COUNT        8'h00
`define WDT_RST_CTRL         8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define WDT_CLK_PERIOD_PS    4000
`define WDT_MS_PERIOD_PS     1000000000
`define WDT_MS_CYCLES        (`WDT_MS_PERIOD_PS / `WDT_CLK_PERIOD_PS)
`define WDT_UNIT_SEC_MS      16'd1000
`define WDT_UNIT_MIN_MS      16'd60000
`define WDT_UNIT_FSEC_MS     16'd1
`define WDT_UNIT_FMIN_MS     16'd60
`define WDT_LED_1HZ_HALF_MS  11'd500
`define WDT_LED_QHZ_HALF_MS  11'd2000
`define WDT_KEYBOARD_RESET_PIN_PULSE      8'h10

`endif

/* File: wdt_pkg.sv */
// Types shared by the watchdog and power LED block
package wdt_pkg;

  // Power LED modes
  typedef enum logic [1:0] {
    LED_HIGH   = 2'h0,
    LED_LOW    = 2'h1,
    LED_1HZ    = 2'h2,
    LED_QTR_HZ = 2'h3
  } led_mode_e;

  // Complete state of the block
  typedef struct packed {
    logic        active;
    led_mode_e   led_mode;
    logic        fast;
    logic        minute;
    logic        rst_edge_en;
    logic        keyboard_reset_pin_en;
    logic        mouse_en;
    logic        kbd_en;
    logic [3:0]  irq_sel;
    logic        status;
    logic [7:0]  reload_val;
    logic [7:0]  count;
    logic [17:0] ms_cnt;
    logic [15:0] unit_cnt;
    logic [10:0] led_ms;
    logic        led_phase;
    logic        led_pin;
    logic [7:0]  keyboard_reset_pin_cnt;
    logic        rst_line_q;
    logic        mouse_q;
    logic        kbd_q;
    logic [7:0]  rdata;
  } wdt_state_s;

endpackage

/* File: watchdog_and_power_led.sv */
// Watchdog timer with power LED driver, reached over a plain register port
//
// Implementation choice: the address-and-strobe port.
`include "wdt_params.svh"
`timescale 1ns/10ps
`default_nettype none

module watchdog_and_power_led #(
  parameter int P_MS_CYCLES = `WDT_MS_CYCLES          // Clock cycles per millisecond
) (
  input  wire logic       I_CLK_SYS,                   // System clock, 250 MHz
  input  wire logic       I_SYS_RST,                   // Synchronous reset, active high
  input  wire logic [7:0] I_ADDR,                      // Register address
  input  wire logic [7:0] I_WDATA,                     // Register write data
  input  wire logic       I_WR,                        // Write strobe
  input  wire logic       I_RD,                        // Read strobe
  output logic      [7:0] O_RDATA,                     // Read data, cycle after strobe
  input  wire logic       I_KEYBOARD_CTRL_RESET_LINE,  // Keyboard controller reset line
  input  wire logic       I_MOUSE_IRQ,                 // Mouse interrupt level
  input  wire logic       I_KEYBOARD_IRQ,              // Keyboard interrupt level
  output logic            O_WATCHDOG_TIMEOUT_OUT_N,    // Timeout output, active low
  output logic            O_KEYBOARD_RESET_PIN_N,      // Keyboard reset pulse, active low
  output logic            O_POWER_LED_OUT,             // Power LED drive
  output logic      [3:0] O_WDT_IRQ_SEL,               // Selected interrupt line number
  output logic            O_WDT_IRQ,                   // Timeout interrupt, active high
  output logic            O_SYSTEM_MGMT_INTERRUPT_N    // System management interrupt
);

  // ****************************************************************
  // State and decode
  // ****************************************************************
  wdt_pkg::wdt_state_s state_reg;
  wdt_pkg::wdt_state_s state_next;

  logic        wr_mode;
  logic        wr_count;
  logic        wr_ctrl;
  logic        ms_tick;
  logic [15:0] unit_len;
  logic        step;
  logic        rst_rise;
  logic        mouse_rise;
  logic        kbd_rise;
  logic        reload;
  logic        zero_evt;
  logic        trig_evt;
  logic        edge_evt;
  logic        evt;
  logic [10:0] led_half;

  // Write decode
  assign wr_mode  = I_WR && (I_ADDR == `WDT_ADDR_MODE);
  assign wr_count = I_WR && (I_ADDR == `WDT_ADDR_COUNT);
  assign wr_ctrl  = I_WR && (I_ADDR == `WDT_ADDR_CTRL);

  // Millisecond base tick shared by the counter and the LED
  assign ms_tick = (state_reg.ms_cnt == 18'(P_MS_CYCLES - 1));

  // Step length in milliseconds for the chosen granularity
  always_comb begin
    unique case ({state_reg.fast, state_reg.minute})
      2'b00:   unit_len = `WDT_UNIT_SEC_MS;
      2'b01:   unit_len = `WDT_UNIT_MIN_MS;
      2'b10:   unit_len = `WDT_UNIT_FSEC_MS;
      default: unit_len = `WDT_UNIT_FMIN_MS;
    endcase
  end

  // A step only happens while the counter holds a non-zero value
  assign step = (state_reg.count != 8'h00) && ms_tick
                && (state_reg.unit_cnt == unit_len - 16'd1);

  // Input edges, inputs already synchronous to the clock
  assign rst_rise   = I_KEYBOARD_CTRL_RESET_LINE && !state_reg.rst_line_q;
  assign mouse_rise = I_MOUSE_IRQ && !state_reg.mouse_q;
  assign kbd_rise   = I_KEYBOARD_IRQ && !state_reg.kbd_q;

  // Reload needs a value that was once loaded
  assign reload = ((mouse_rise && state_reg.mouse_en) || (kbd_rise && state_reg.kbd_en))
                  && (state_reg.reload_val != 8'h00);

  // Timeout sources
  assign zero_evt = step && (state_reg.count == 8'h01) && !wr_count && !reload;
  assign trig_evt = wr_ctrl && I_WDATA[`WDT_CTRL_TRIG_BIT];
  assign edge_evt = rst_rise && state_reg.rst_edge_en;
  assign evt      = zero_evt || trig_evt || edge_evt;

  // LED half period
  assign led_half = (state_reg.led_mode == wdt_pkg::LED_QTR_HZ) ? `WDT_LED_QHZ_HALF_MS
                                                                : `WDT_LED_1HZ_HALF_MS;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next            = state_reg;
    state_next.rst_line_q = I_KEYBOARD_CTRL_RESET_LINE;
    state_next.mouse_q    = I_MOUSE_IRQ;
    state_next.kbd_q      = I_KEYBOARD_IRQ;

    // Configuration writes
    if (I_WR && (I_ADDR == `WDT_ADDR_ACTIVATE)) begin
      state_next.active = I_WDATA[`WDT_ACT_BIT];
    end
    if (wr_mode) begin
      state_next.led_mode    = wdt_pkg::led_mode_e'(I_WDATA[`WDT_MODE_LED_HI:`WDT_MODE_LED_LO]);
      state_next.fast        = I_WDATA[`WDT_MODE_FAST_BIT];
      state_next.minute      = I_WDATA[`WDT_MODE_MINUTE_BIT];
      state_next.rst_edge_en = I_WDATA[`WDT_MODE_RSTEDGE_BIT];
      state_next.keyboard_reset_pin_en    = I_WDATA[`WDT_MODE_KEYBOARD_RESET_PIN_BIT];
    end
    if (wr_ctrl) begin
      state_next.mouse_en = I_WDATA[`WDT_CTRL_MOUSE_BIT];
      state_next.kbd_en   = I_WDATA[`WDT_CTRL_KBD_BIT];
      state_next.irq_sel  = I_WDATA[`WDT_CTRL_SEL_HI:`WDT_CTRL_SEL_LO];
      if (!I_WDATA[`WDT_CTRL_STATUS_BIT]) begin
        state_next.status = 1'b0;
      end
    end

    // Millisecond prescaler and step counter
    state_next.ms_cnt = ms_tick ? 18'h0 : state_reg.ms_cnt + 18'h1;
    if (ms_tick) begin
      state_next.unit_cnt = (state_reg.unit_cnt >= unit_len - 16'd1) ? 16'h0
                                                                     : state_reg.unit_cnt + 16'h1;
    end

    // Countdown: a write beats a reload, a reload beats a step
    if (wr_count) begin
      state_next.count    = I_WDATA;
      state_next.ms_cnt   = 18'h0;
      state_next.unit_cnt = 16'h0;
      if (I_WDATA != 8'h00) begin
        state_next.reload_val = I_WDATA;
      end
    end else if (reload) begin
      state_next.count    = state_reg.reload_val;
      state_next.ms_cnt   = 18'h0;
      state_next.unit_cnt = 16'h0;
    end else if (step) begin
      state_next.count = state_reg.count - 8'h01;
    end

    // A timeout stops the count unless a count write or reload lands in the same cycle; set wins over a clearing write
    if (evt) begin
      state_next.status = 1'b1;
      if (!wr_count && !reload) begin
        state_next.count = 8'h00;
      end
    end

    // Keyboard reset pulse; a fresh event restarts its full width
    if (evt && state_reg.keyboard_reset_pin_en && state_reg.active) begin
      state_next.keyboard_reset_pin_cnt = `WDT_KEYBOARD_RESET_PIN_PULSE;
    end else if (state_reg.keyboard_reset_pin_cnt != 8'h00) begin
      state_next.keyboard_reset_pin_cnt = state_reg.keyboard_reset_pin_cnt - 8'h01;
    end

    // LED cadence; shares the prescaler so a counter load may jitter one phase
    if (ms_tick) begin
      if (state_reg.led_ms >= led_half - 11'd1) begin
        state_next.led_ms    = 11'h0;
        state_next.led_phase = !state_reg.led_phase;
      end else begin
        state_next.led_ms = state_reg.led_ms + 11'h1;
      end
    end
    if (!state_reg.active) begin
      state_next.led_pin = 1'b0;
    end else begin
      unique case (state_reg.led_mode)
        wdt_pkg::LED_HIGH:   state_next.led_pin = 1'b1;
        wdt_pkg::LED_LOW:    state_next.led_pin = 1'b0;
        wdt_pkg::LED_1HZ:    state_next.led_pin = state_reg.led_phase;
        wdt_pkg::LED_QTR_HZ: state_next.led_pin = state_reg.led_phase;
      endcase
    end

    // Read data, valid the cycle after the strobe only
    state_next.rdata = 8'h00;
    if (I_RD) begin
      unique case (I_ADDR)
        `WDT_ADDR_ACTIVATE: state_next.rdata = {7'h00, state_reg.active};
        `WDT_ADDR_MODE:     state_next.rdata = {state_reg.led_mode, 1'b0, state_reg.fast,
                                                state_reg.minute, state_reg.rst_edge_en,
                                                state_reg.keyboard_reset_pin_en, 1'b0};
        `WDT_ADDR_COUNT:    state_next.rdata = state_reg.count;
        `WDT_ADDR_CTRL:     state_next.rdata = {state_reg.mouse_en, state_reg.kbd_en, 1'b0,
                                                state_reg.status, state_reg.irq_sel};
        default:            state_next.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      state_reg          <= '0;
      state_reg.active   <= 1'(`WDT_RST_ACTIVATE >> `WDT_ACT_BIT);
      state_reg.count    <= `WDT_RST_COUNT;
      state_reg.irq_sel  <= 4'(`WDT_RST_CTRL);
      state_reg.led_mode <= wdt_pkg::led_mode_e'(2'(`WDT_RST_MODE >> `WDT_MODE_LED_LO));
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs; the timeout level is gated by activation
  assign O_RDATA                   = state_reg.rdata;
  assign O_POWER_LED_OUT           = state_reg.led_pin;
  assign O_WATCHDOG_TIMEOUT_OUT_N  = !(state_reg.status && state_reg.active);
  assign O_KEYBOARD_RESET_PIN_N    = (state_reg.keyboard_reset_pin_cnt == 8'h00);
  assign O_WDT_IRQ_SEL             = state_reg.irq_sel;
  assign O_WDT_IRQ                 = state_reg.status && state_reg.active;
  assign O_SYSTEM_MGMT_INTERRUPT_N = !(O_WDT_IRQ && state_reg.irq_sel == `WDT_SEL_SMI);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  sequence s_evt_hit;
    evt && state_reg.keyboard_reset_pin_en && state_reg.active;
  endsequence
  sequence s_pulse_low;
    (!O_KEYBOARD_RESET_PIN_N) [*8];
  endsequence

  a_led_fixed_high: assert property (state_reg.active && state_reg.led_mode == wdt_pkg::LED_HIGH
    |=> O_POWER_LED_OUT) else $error("LED not high in mode 00");
  a_second_step_len: assert property (step && !state_reg.fast && !state_reg.minute
    |-> state_reg.unit_cnt == 16'd999) else $error("Second step length wrong");
  a_fast_minute_len: assert property (step && state_reg.fast && state_reg.minute
    |-> state_reg.unit_cnt == 16'd59) else $error("Fast minute step length wrong");
  a_edge_event: assert property (rst_rise && state_reg.rst_edge_en
    |=> state_reg.status) else $error("Reset edge raised no timeout");
  a_keyboard_reset_pin_pulse: assert property (s_evt_hit |=> s_pulse_low)
    else $error("Keyboard reset pulse too short");
  a_count_load: assert property (wr_count && I_WDATA != 8'h00 && !I_RD
    |=> state_reg.count == $past(I_WDATA)) else $error("Count not loaded");
  a_zero_holds: assert property (state_reg.count == 8'h00 && !wr_count && !reload
    |=> state_reg.count == 8'h00) else $error("Disabled counter moved");
  a_irq_reload: assert property (reload && !wr_count
    |=> state_reg.count == $past(state_reg.reload_val)) else $error("Reload missed");
  a_live_read: assert property (I_RD && I_ADDR == `WDT_ADDR_COUNT
    |=> O_RDATA == $past(state_reg.count)) else $error("Count read not live");
  a_trigger_event: assert property (trig_evt |=> state_reg.status ##1 state_reg.status
    || $past(wr_ctrl)) else $error("Trigger raised no timeout");
  a_status_sticky: assert property (state_reg.status && !wr_ctrl
    |=> state_reg.status) else $error("Status dropped without write");
  a_smi_route: assert property (state_reg.status && state_reg.active
    && state_reg.irq_sel == `WDT_SEL_SMI |-> !O_SYSTEM_MGMT_INTERRUPT_N)
    else $error("Timeout not routed to SMI");
  a_zero_timeout: assert property (step && state_reg.count == 8'h01 && !wr_count && !reload
    |=> state_reg.status && state_reg.count == 8'h00 && !O_WATCHDOG_TIMEOUT_OUT_N
        || !state_reg.active) else $error("Expiry not reported");
  a_inactive_quiet: assert property (!state_reg.active
    |=> !O_POWER_LED_OUT || state_reg.active) else $error("LED driven while inactive");

endmodule  // watchdog_and_power_led

`default_nettype wire

/* File: wdt_host_model.sv */
// Host-side model: interrupt sources, reset line and keyboard reset pin monitor
`timescale 1ns/10ps
`default_nettype none

module wdt_host_model (
  input  wire logic clk,        // System clock
  input  wire logic keyboard_reset_pin_n,    // Keyboard reset pin from the block
  output logic      mouse_irq,  // Mouse interrupt level
  output logic      kbd_irq,    // Keyboard interrupt level
  output logic      rst_line    // Keyboard controller reset line
);
  int low_cnt = 0;
  int low_len = 0;

  // All sources idle until a scenario asks for an edge
  initial begin
    mouse_irq = 1'b0;
    kbd_irq   = 1'b0;
    rst_line  = 1'b0;
  end

  // Width of the last low pulse seen on the reset pin
  always @(posedge clk) begin
    if (keyboard_reset_pin_n === 1'b0) low_cnt <= low_cnt + 1;
    else if (low_cnt != 0) begin
      low_len <= low_cnt;
      low_cnt <= 0;
    end
  end

  // Forget the last pulse before a new scenario
  task automatic clear_len();
    @(posedge clk);
    low_len <= 0;
  endtask

  // Held two cycles so the edge detector cannot miss it
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: mouse_irq <= 1'b1;
      1: kbd_irq <= 1'b1;
      default: rst_line <= 1'b1;
    endcase
    repeat (2) @(posedge clk);
    mouse_irq <= 1'b0;
    kbd_irq   <= 1'b0;
    rst_line  <= 1'b0;
  endtask
endmodule // wdt_host_model
`default_nettype wire

/* File: watchdog_and_power_led_test.sv */
// Self-checking bench for the watchdog and power LED block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(act, exp) begin comparisons++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h want %h", $time, (act), (exp)); end end

module watchdog_and_power_led_test;
  localparam int MS = 10;  // Short millisecond keeps the run brief
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       mouse, kbd, kline, to_n, keyboard_reset_pin_n, led, irq, smi_n;
  logic [3:0] sel;
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         n;

  // ****************************************************************
  // Clock, design and host model
  // ****************************************************************
  always #2 clk = ~clk;

  watchdog_and_power_led #(.P_MS_CYCLES(MS)) watchdog_and_power_led_inst (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_KEYBOARD_CTRL_RESET_LINE(kline),
    .I_MOUSE_IRQ(mouse), .I_KEYBOARD_IRQ(kbd), .O_WATCHDOG_TIMEOUT_OUT_N(to_n),
    .O_KEYBOARD_RESET_PIN_N(keyboard_reset_pin_n), .O_POWER_LED_OUT(led), .O_WDT_IRQ_SEL(sel),
    .O_WDT_IRQ(irq), .O_SYSTEM_MGMT_INTERRUPT_N(smi_n));

  wdt_host_model wdt_host_model_inst (.clk(clk), .keyboard_reset_pin_n(keyboard_reset_pin_n), .mouse_irq(mouse),
    .kbd_irq(kbd), .rst_line(kline));

  // ****************************************************************
  // Bus and timing tasks
  // ****************************************************************
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // One-cycle write; ends just after the sampling edge
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_irq(input int lim, output int c);
    c = 0;
    while (irq !== 1'b1 && c < lim) begin
      tick(1);
      c++;
    end
  endtask

  // Load N, expect the event after N units of ulen ms
  task automatic run_to(input logic [7:0] cnt, input int ulen, output logic ok);
    int e;
    int c;
    e = cnt * ulen * MS;
    wreg(`WDT_ADDR_COUNT, cnt);
    wait_irq(e + 50, c);
    ok = (c >= e - 2) && (c <= e + 3);
  endtask

  // Mouse or keyboard edge late in a 2 ms run restarts the full count
  task automatic reload_case(input int which, output logic ok);
    wreg(`WDT_ADDR_COUNT, 8'h02);
    tick(15);
    wdt_host_model_inst.pulse(which);
    wait_irq(100, n);
    ok = (n >= 17) && (n <= 23);
  endtask

  // Spacing between two LED transitions, no bus writes meanwhile
  task automatic led_half(input int half, output logic ok);
    logic l;
    int c;
    c = 0;
    l = led;
    while (led === l && c < half + 50) begin
      tick(1);
      c++;
    end
    l = led;
    c = 0;
    while (led === l && c < half + 50) begin
      tick(1);
      c++;
    end
    ok = (c >= half - 12) && (c <= half + 12);
  endtask

  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hang guard, well past the expected run length
  initial begin
    #380000;
    n_mismatch++;
    stop_test();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [7:0] d;
    logic       ok;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values, reserved bits and an unmapped place
    rreg(`WDT_ADDR_ACTIVATE, d); `CHECK(d, 8'h00)
    rreg(`WDT_ADDR_COUNT, d); `CHECK(d, 8'h00)
    rreg(`WDT_ADDR_MODE, d); `CHECK(d, 8'h00)
    rreg(`WDT_ADDR_CTRL, d); `CHECK(d, 8'h00)
    `CHECK(led, 1'b0)
    wreg(`WDT_ADDR_ACTIVATE, 8'hff); rreg(`WDT_ADDR_ACTIVATE, d); `CHECK(d, 8'h01)
    wreg(`WDT_ADDR_MODE, 8'hff); rreg(`WDT_ADDR_MODE, d); `CHECK(d, 8'hde)
    wreg(`WDT_ADDR_CTRL, 8'hcf); rreg(`WDT_ADDR_CTRL, d); `CHECK(d, 8'hcf)
    wreg(8'h40, 8'hff); rreg(8'h40, d); `CHECK(d, 8'h00)
    // Fast seconds with reset pulse on, LED held high
    wreg(`WDT_ADDR_CTRL, 8'h00);
    wreg(`WDT_ADDR_MODE, 8'h12); tick(1); `CHECK(led, 1'b1)
    wreg(`WDT_ADDR_COUNT, 8'h05); tick(15);
    rreg(`WDT_ADDR_COUNT, d); `CHECK(d, 8'h04)
    run_to(8'h03, 1, ok); `CHECK(ok, 1'b1)
    rreg(`WDT_ADDR_COUNT, d); `CHECK(d, 8'h00)
    `CHECK(to_n, 1'b0)
    rreg(`WDT_ADDR_CTRL, d); `CHECK(d, 8'h10)
    tick(20); `CHECK(wdt_host_model_inst.low_len, `WDT_KEYBOARD_RESET_PIN_PULSE)
    wreg(`WDT_ADDR_CTRL, 8'h00); `CHECK(irq, 1'b0)
    // Pulse disabled, then a zero count never expires
    wdt_host_model_inst.clear_len();
    wreg(`WDT_ADDR_MODE, 8'h10); run_to(8'h01, 1, ok); `CHECK(ok, 1'b1)
    tick(20); `CHECK(wdt_host_model_inst.low_len, 0)
    wreg(`WDT_ADDR_CTRL, 8'h00); wreg(`WDT_ADDR_COUNT, 8'h00);
    tick(60); `CHECK(irq, 1'b0)
    // Fast minute, then plain seconds
    wreg(`WDT_ADDR_MODE, 8'h18); run_to(8'h01, 60, ok); `CHECK(ok, 1'b1)
    wreg(`WDT_ADDR_CTRL, 8'h00);
    wreg(`WDT_ADDR_MODE, 8'h00); run_to(8'h01, 1000, ok); `CHECK(ok, 1'b1)
    // Reload by mouse, then by keyboard
    wreg(`WDT_ADDR_MODE, 8'h10); wreg(`WDT_ADDR_CTRL, 8'h80);
    reload_case(0, ok); `CHECK(ok, 1'b1)
    wreg(`WDT_ADDR_CTRL, 8'h40);
    reload_case(1, ok); `CHECK(ok, 1'b1)
    // Software trigger, bit reads back as zero
    wreg(`WDT_ADDR_CTRL, 8'h00); wreg(`WDT_ADDR_CTRL, 8'h20);
    tick(1); `CHECK(irq, 1'b1)
    rreg(`WDT_ADDR_CTRL, d); `CHECK(d, 8'h10)
    // Reset-line edge enabled, then disabled
    wreg(`WDT_ADDR_CTRL, 8'h00); wreg(`WDT_ADDR_MODE, 8'h14);
    wdt_host_model_inst.pulse(2); tick(2); `CHECK(irq, 1'b1)
    wreg(`WDT_ADDR_CTRL, 8'h00); wreg(`WDT_ADDR_MODE, 8'h10);
    wdt_host_model_inst.pulse(2); tick(2); `CHECK(irq, 1'b0)
    // Routing to the management interrupt or elsewhere
    wreg(`WDT_ADDR_CTRL, 8'h22); tick(2);
    `CHECK(smi_n, 1'b0)
    `CHECK(sel, `WDT_SEL_SMI)
    wreg(`WDT_ADDR_CTRL, 8'h05); wreg(`WDT_ADDR_CTRL, 8'h25); tick(2);
    `CHECK(smi_n, 1'b1)
    `CHECK(sel, 4'h5)
    // Deactivated block keeps its outputs quiet
    wreg(`WDT_ADDR_MODE, 8'h00); wreg(`WDT_ADDR_ACTIVATE, 8'h00); tick(2);
    `CHECK(to_n, 1'b1)
    `CHECK(led, 1'b0)
    wreg(`WDT_ADDR_ACTIVATE, 8'h01); wreg(`WDT_ADDR_CTRL, 8'h00);
    // LED low, 1Hz and 0.25Hz blink
    wreg(`WDT_ADDR_MODE, 8'h40); tick(1); `CHECK(led, 1'b0)
    wreg(`WDT_ADDR_MODE, 8'h80); led_half(500 * MS, ok); `CHECK(ok, 1'b1)
    wreg(`WDT_ADDR_MODE, 8'hc0); led_half(2000 * MS, ok); `CHECK(ok, 1'b1)
    stop_test();
  end
endmodule // watchdog_and_power_led_test
`default_nettype wire
